// ==== design/pefg_pkg.sv ====
// package for the port e/f/g alternate function override block
package pefg_pkg;
    // ---------------------------------------------------------------
    // register map (apb byte addresses, one word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00; // peripheral enables and modes
    localparam logic [7:0] PORTE_OFS = 8'h04; // port e data/dir
    localparam logic [7:0] PORTF_OFS = 8'h08; // port f data/dir
    localparam logic [7:0] PORTG_OFS = 8'h0c; // port g data/dir
    localparam logic [7:0] PINS_OFS = 8'h10; // pin readback, read only
    localparam logic [7:0] STAT_OFS = 8'h14; // effective dir, read only
    // ---------------------------------------------------------------
    // control register bit positions
    // ---------------------------------------------------------------
    localparam int PULLUP_OFF_BIT = 2; // global pull-up off, wins over every pull-up
    localparam int RXEN_BIT = 0; // usart0 receive enable
    localparam int TXEN_BIT = 1; // usart0 transmit enable
    localparam int SYNC_BIT = 3; // usart0 synchronous mode
    localparam int SCAN_BIT = 4; // boundary-scan enable
    localparam int ASYNC_BIT = 5; // asynchronous timer oscillator
    localparam int XMEM_BIT = 6; // external memory enable
    localparam int LEGACY_BIT = 7; // legacy compatibility fuse
    localparam int PROG_BIT = 8; // serial programming active
    localparam int OC3_LSB = 9; // timer3 compare enables a,b,c
    localparam int IRQ_LSB = 12; // external irq enables 7:4
    localparam int CTRL_W = 16; // control width
    localparam logic [15:0] CTRL_RST = 16'h0000; // reset value
    localparam logic [7:0] PORT_RST = 8'h00; // port data/dir reset
    // ---------------------------------------------------------------
    // per-pin override bundle
    // ---------------------------------------------------------------
    typedef struct packed {
        logic pullOvrEn; // pullup_override_en
        logic pullOvrVal; // pullup_override_val
        logic dirOvrEn; // dir_override_en
        logic dirOvrVal; // dir_override_val
        logic outOvrEn; // outval_override_en
        logic outOvrVal; // outval_override_val
        logic dinOvrEn; // input_en_override_en
        logic dinOvrVal; // input_en_override_val
    } pefg_ovr_t;
    // peripheral signals that drive pins
    typedef struct packed {
        logic usartClkOut; // usart0_ext_clock output
        logic usartTxLine; // usart0_tx_line
        logic progSerialOut; // prog_serial_out
        logic [2:0] timer3Cmp; // compare a,b,c levels
        logic scanDataOut; // scan data out
        logic scanShiftState; // tap in shift-ir or shift-dr
        logic memAle; // address latch enable
        logic memRd; // read strobe
        logic memWr; // write strobe
    } pefg_periph_t;
endpackage

// ==== design/pefg_override.sv ====
// port e/f/g alternate function override logic with an apb register file
`timescale 1ns/10ps
`default_nettype none
module pefg_override
    import pefg_pkg::*;
(
    input wire logic ref_clk, // 20 mhz system clock
    input wire logic rst, // asynchronous, active high
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire pefg_pkg::pefg_periph_t periph, // peripheral drive signals
    input wire logic [7:0] portEIn, // pin levels port e
    input wire logic [7:0] portFIn, // pin levels port f
    input wire logic [4:0] portGIn, // pin levels port g
    output logic [7:0] portEOut, // pad output value
    output logic [7:0] portEOe, // pad output enable
    output logic [7:0] portEPull, // pad pull-up enable
    output logic [7:0] portFOut, // pad output value
    output logic [7:0] portFOe, // pad output enable
    output logic [7:0] portFPull, // pad pull-up enable
    output logic [4:0] portGOut, // pad output value
    output logic [4:0] portGOe, // pad output enable
    output logic [4:0] portGPull, // pad pull-up enable
    output logic [7:0] portEDin, // gated digital input to peripherals
    output logic [7:0] portFDin, // gated digital input
    output logic [4:0] portGDin, // gated digital input
    output logic usartRxIn, // usart0_rx_line sample
    output logic usartClkIn, // usart0_ext_clock input
    output logic progSerialIn, // prog_serial_in sample
    output logic scanDataIn, // scan data input
    output logic scanModeSel, // tap mode select
    output logic scanClk // tap clock level
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl; // enables and modes
    logic [7:0] dataE, dirE, dataF, dirF; // port e/f data and direction
    logic [4:0] dataG, dirG; // port g data and direction
    pefg_ovr_t ovrE [8]; // override bundles per pin
    pefg_ovr_t ovrF [8];
    pefg_ovr_t ovrG [5];
    logic [7:0] effDirE, effDirF; // resolved directions for readback
    logic [4:0] effDirG;

    // control aliases
    logic pullupOff; // global pull-up off
    logic rxEn; // usart0_receive_enable
    logic txEn; // usart0_transmit_enable
    logic syncSel; // usart0_sync_select
    logic scanEn; // scan_port_enable
    logic asyncSel; // async_timer_osc_sel
    logic xmemEn; // ext_mem_enable, or forced by legacy mode
    logic legacy; // legacy compatibility fuse
    logic progEn; // serial programming in progress
    logic [2:0] oc3En; // timer3 compare enables a,b,c
    logic [3:0] irqEn; // external irq enables pe7:4
    assign pullupOff = ctrl[PULLUP_OFF_BIT];
    assign rxEn = ctrl[RXEN_BIT];
    assign txEn = ctrl[TXEN_BIT];
    assign syncSel = ctrl[SYNC_BIT];
    assign scanEn = ctrl[SCAN_BIT];
    assign asyncSel = ctrl[ASYNC_BIT];
    assign xmemEn = ctrl[XMEM_BIT] | legacy;
    assign legacy = ctrl[LEGACY_BIT];
    assign progEn = ctrl[PROG_BIT];
    assign oc3En = ctrl[OC3_LSB+2:OC3_LSB];
    assign irqEn = ctrl[IRQ_LSB+3:IRQ_LSB];

    // ---------------------------------------------------------------
    // pin resolution
    // ---------------------------------------------------------------
    typedef struct packed {
        logic oe; // drive enable
        logic out; // drive value
        logic pull; // pull-up on
        logic die; // digital input enabled
    } pefg_pad_t;

    // generic override merge shared by every pin
    // the pull-up off bit is applied last, so no override can bring a pull-up back
    function automatic pefg_pad_t resolve(input pefg_ovr_t o, input logic dat, input logic dir,
                                          input logic pullOffIn);
        pefg_pad_t p;
        logic pu;
        p.oe = o.dirOvrEn ? o.dirOvrVal : dir;
        p.out = o.outOvrEn ? o.outOvrVal : dat;
        pu = o.pullOvrEn ? o.pullOvrVal : (dat & ~dir & ~pullOffIn);
        p.pull = pu & ~pullOffIn;
        p.die = o.dinOvrEn ? o.dinOvrVal : 1'b1;
        return p;
    endfunction

    // ---------------------------------------------------------------
    // override tables for port e
    // ---------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            ovrE[i] = '0;
        end
        // pe0: receiver or programming input
        // the programming input needs no override, it reads the pin through the tap below
        ovrE[0].pullOvrEn = rxEn;
        ovrE[0].pullOvrVal = dataE[0] & ~pullupOff;
        ovrE[0].dirOvrEn = rxEn;
        ovrE[0].dirOvrVal = 1'b0;
        // pe1: transmitter or programming output
        ovrE[1].pullOvrEn = txEn | progEn;
        ovrE[1].dirOvrEn = txEn | progEn;
        ovrE[1].dirOvrVal = 1'b1;
        ovrE[1].outOvrEn = txEn | progEn;
        ovrE[1].outOvrVal = progEn ? periph.progSerialOut : periph.usartTxLine;
        // pe2: direction register decides clock in or out
        // no direction override here: software sets the direction bit to be clock master
        ovrE[2].outOvrEn = syncSel;
        ovrE[2].outOvrVal = periph.usartClkOut;
        // pe3: compare channel a named by the pin
        ovrE[3].outOvrEn = oc3En[0];
        ovrE[3].outOvrVal = periph.timer3Cmp[0];
        // pe5:4 compare c and b
        ovrE[4].outOvrEn = oc3En[1];
        ovrE[4].outOvrVal = periph.timer3Cmp[1];
        ovrE[5].outOvrEn = oc3En[2];
        ovrE[5].outOvrVal = periph.timer3Cmp[2];
        for (int i = 4; i < 8; i++)
        begin
            ovrE[i].dinOvrEn = irqEn[i-4];
            ovrE[i].dinOvrVal = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // override tables for port f; pf3:0 stay all zero
    // ---------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            ovrF[i] = '0;
        end
        for (int i = 4; i < 8; i++)
        begin
            ovrF[i].pullOvrEn = scanEn;
            ovrF[i].pullOvrVal = (i != 6);
            ovrF[i].dirOvrEn = scanEn;
            ovrF[i].dinOvrEn = scanEn;
            ovrF[i].dinOvrVal = 1'b0;
        end
        // pf6 turns around only while the tap shifts, so a shared net sees no contention otherwise
        ovrF[6].dirOvrVal = periph.scanShiftState;
        ovrF[6].outOvrEn = scanEn;
        ovrF[6].outOvrVal = periph.scanDataOut;
    end

    // ---------------------------------------------------------------
    // override tables for port g
    // ---------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 5; i++)
        begin
            ovrG[i] = '0;
        end
        for (int i = 3; i < 5; i++)
        begin
            ovrG[i].pullOvrEn = asyncSel;
            ovrG[i].dirOvrEn = asyncSel;
            ovrG[i].dinOvrEn = asyncSel;
        end
        // legacy mode reuses the memory enable, so pg2:0 stay strobes there
        for (int i = 0; i < 3; i++)
        begin
            ovrG[i].pullOvrEn = xmemEn;
            ovrG[i].dirOvrEn = xmemEn;
            ovrG[i].dirOvrVal = 1'b1;
            ovrG[i].outOvrEn = xmemEn;
        end
        ovrG[2].outOvrVal = periph.memAle;
        ovrG[1].outOvrVal = periph.memRd;
        ovrG[0].outOvrVal = periph.memWr;
    end

    // ---------------------------------------------------------------
    // merge per pin and drive the pads
    // ---------------------------------------------------------------
    always_comb
    begin
        pefg_pad_t p;
        p = '0;
        for (int i = 0; i < 8; i++)
        begin
            p = resolve(ovrE[i], dataE[i], dirE[i], pullupOff);
            portEOe[i] = p.oe;
            portEOut[i] = p.out;
            portEPull[i] = p.pull;
            portEDin[i] = p.die & portEIn[i];
            effDirE[i] = p.oe;
            p = resolve(ovrF[i], dataF[i], dirF[i], pullupOff);
            portFOe[i] = p.oe & ~legacy;
            portFOut[i] = p.out;
            // reset clears the scan enable, so this reset term never turns a scan pull-up on
            portFPull[i] = p.pull | (rst & scanEn & ovrF[i].pullOvrVal & ~pullupOff);
            portFDin[i] = p.die & portFIn[i];
            effDirF[i] = p.oe & ~legacy;
        end
        for (int i = 0; i < 5; i++)
        begin
            p = resolve(ovrG[i], dataG[i], dirG[i], pullupOff);
            portGOe[i] = p.oe;
            portGOut[i] = p.out;
            portGPull[i] = p.pull;
            portGDin[i] = p.die & portGIn[i];
            effDirG[i] = p.oe;
        end
    end

    // ---------------------------------------------------------------
    // peripheral input taps
    // ---------------------------------------------------------------
    assign usartRxIn = portEIn[0];
    assign progSerialIn = portEIn[0];
    assign usartClkIn = portEIn[2];
    assign scanDataIn = portFIn[7] & scanEn;
    assign scanModeSel = portFIn[5] & scanEn;
    assign scanClk = portFIn[4] & scanEn;

    // ---------------------------------------------------------------
    // apb slave: zero wait states
    // ---------------------------------------------------------------
    logic wrStb;
    logic mapped;
    assign wrStb = psel & penable & pwrite;
    assign pready = 1'b1; // every access completes in its access phase
    assign mapped = (paddr == CTRL_OFS) || (paddr == PORTE_OFS) || (paddr == PORTF_OFS) ||
                    (paddr == PORTG_OFS) || (paddr == PINS_OFS) || (paddr == STAT_OFS);
    // unmapped words answer with an error and read as zero; writes to them are dropped
    assign pslverr = psel & penable & ~mapped;

    // ---------------------------------------------------------------
    // control register writes
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= CTRL_RST;
        end
        else if (wrStb && paddr == CTRL_OFS)
        begin
            ctrl <= pwdata[CTRL_W-1:0];
        end
    end

    // ---------------------------------------------------------------
    // port data/direction writes: data in [7:0], direction in [15:8]
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dataE <= PORT_RST;
            dirE <= PORT_RST;
            dataF <= PORT_RST;
            dirF <= PORT_RST;
            dataG <= PORT_RST[4:0];
            dirG <= PORT_RST[4:0];
        end
        else if (wrStb)
        begin
            if (paddr == PORTE_OFS)
            begin
                dataE <= pwdata[7:0];
                dirE <= pwdata[15:8];
            end
            if (paddr == PORTF_OFS)
            begin
                dataF <= pwdata[7:0];
                dirF <= pwdata[15:8];
            end
            // legacy mode keeps port g out of general use
            if (paddr == PORTG_OFS && !legacy)
            begin
                dataG <= pwdata[4:0];
                dirG <= pwdata[12:8];
            end
        end
    end

    // ---------------------------------------------------------------
    // read data is registered so it is stable during the access phase
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                CTRL_OFS: prdata <= {16'h0000, ctrl};
                PORTE_OFS: prdata <= {16'h0000, dirE, dataE};
                PORTF_OFS: prdata <= {16'h0000, dirF, dataF};
                PORTG_OFS: prdata <= {19'h0, dirG, 3'h0, dataG};
                PINS_OFS: prdata <= {11'h0, portGIn, portFIn, portEIn};
                STAT_OFS: prdata <= {11'h0, effDirG, effDirF, effDirE};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule // pefg_override
`default_nettype wire

// ==== test/pefg_props.sv ====
// assertion checker for the port e/f/g override block
`timescale 1ns/10ps
`default_nettype none
module pefg_props
    import pefg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire pefg_pkg::pefg_periph_t periph,
    input wire logic [7:0] portEOut,
    input wire logic [7:0] portEOe,
    input wire logic [7:0] portEPull,
    input wire logic [7:0] portFOe,
    input wire logic [7:0] portFPull,
    input wire logic [4:0] portGOut,
    input wire logic [4:0] portGOe,
    input wire logic [4:0] portGPull
);
    // ------------------------------------------------
    // shadows of the written words
    // ------------------------------------------------
    logic [15:0] ctl; // control word as the block holds it
    logic eBit0; // port e data bit 0
    logic wrDone; // a write lands at this edge
    assign wrDone = psel && penable && pwrite && pready;
    // shadows load on the block's own edge, so both agree in every cycle
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            ctl <= 16'h0;
        else if (wrDone && paddr == CTRL_OFS)
            ctl <= pwdata[15:0];
    // port e data bit, needed for the receiver pull-up
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            eBit0 <= 1'b0;
        else if (wrDone && paddr == PORTE_OFS)
            eBit0 <= pwdata[0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rx_in; ctl[RXEN_BIT] |-> !portEOe[0]; endproperty
    a_rx_in: assert property (p_rx_in) else $error("receive pin driven");
    property p_rx_pull; ctl[RXEN_BIT] |-> portEPull[0] == (eBit0 && !ctl[PULLUP_OFF_BIT]); endproperty
    a_rx_pull: assert property (p_rx_pull) else $error("receive pin pull-up wrong");
    property p_tx; ctl[TXEN_BIT] && !ctl[PROG_BIT] |-> portEOe[1] && !portEPull[1]
        && portEOut[1] == periph.usartTxLine; endproperty
    a_tx: assert property (p_tx) else $error("transmit pin wrong");
    property p_cmp_a; ctl[OC3_LSB] && !ctl[LEGACY_BIT] |-> portEOut[3] == periph.timer3Cmp[0]; endproperty
    a_cmp_a: assert property (p_cmp_a) else $error("compare a not on pin");
    property p_scan; ctl[SCAN_BIT] && !ctl[LEGACY_BIT] && !ctl[PULLUP_OFF_BIT] |->
        portFOe[6] == periph.scanShiftState && portFPull[7:4] == 4'hb && portFOe[7] == 1'b0; endproperty
    a_scan: assert property (p_scan) else $error("scan pins wrong");
    property p_legacy_f; ctl[LEGACY_BIT] |-> portFOe == 8'h00; endproperty
    a_legacy_f: assert property (p_legacy_f) else $error("port f driven in legacy mode");
    property p_async; ctl[ASYNC_BIT] |-> portGOe[4:3] == 2'h0 && portGPull[4:3] == 2'h0; endproperty
    a_async: assert property (p_async) else $error("oscillator pins not freed");
    property p_xmem; ctl[XMEM_BIT] |-> portGOe[2:0] == 3'h7 && portGPull[2:0] == 3'h0
        && portGOut[2:0] == {periph.memAle, periph.memRd, periph.memWr}; endproperty
    a_xmem: assert property (p_xmem) else $error("memory strobes wrong");
    property p_pud; ctl[PULLUP_OFF_BIT] && !ctl[SCAN_BIT] |-> portEPull == 8'h00 && portFPull == 8'h00
        && portGPull == 5'h00; endproperty
    a_pud: assert property (p_pud) else $error("pull-up on while disabled");
    c_rx: cover property (ctl[RXEN_BIT] && portEPull[0]);
    c_scan: cover property (ctl[SCAN_BIT] && portFOe[6]);
    c_xmem: cover property (ctl[XMEM_BIT] && portGOut[0]);
endmodule // pefg_props
bind pefg_override pefg_props pefg_props_inst (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .periph, .portEOut, .portEOe, .portEPull, .portFOe, .portFPull, .portGOut, .portGOe, .portGPull);
`default_nettype wire

// ==== test/pefg_board_model.sv ====
// board model of the pads: own driver, pull-up, outside source
`timescale 1ns/10ps
`default_nettype none
module pefg_board_model
(
    input wire logic [7:0] portEOut,
    input wire logic [7:0] portEOe,
    input wire logic [7:0] portEPull,
    input wire logic [7:0] portFOut,
    input wire logic [7:0] portFOe,
    input wire logic [7:0] portFPull,
    input wire logic [4:0] portGOut,
    input wire logic [4:0] portGOe,
    input wire logic [4:0] portGPull,
    input wire logic [20:0] ext, // outside drive, new each step so a released pin never keeps old data
    output logic [7:0] portEIn,
    output logic [7:0] portFIn,
    output logic [4:0] portGIn
);
    // the pad driver wins, else a pull-up reads one, else the outside source
    assign portEIn = (portEOe & portEOut) | (~portEOe & (portEPull | ext[7:0]));
    assign portFIn = (portFOe & portFOut) | (~portFOe & (portFPull | ext[15:8]));
    assign portGIn = (portGOe & portGOut) | (~portGOe & (portGPull | ext[20:16]));
endmodule // pefg_board_model
`default_nettype wire

// ==== test/pefg_override_tb.sv ====
// self-checking bench for the port e/f/g override block
`timescale 1ns/10ps
`default_nettype none
module pefg_override_tb;
    import pefg_pkg::*;
    // ------------------------------------------------
    // signals, instances, clock
    // ------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [31:0] pwdata = 32'h0, prdata;
    pefg_periph_t periph = 12'h000;
    logic [20:0] ext = 21'h0; // outside pin drive
    logic [7:0] portEIn, portFIn, portEOut, portEOe, portEPull, portFOut, portFOe, portFPull, portEDin, portFDin;
    logic [4:0] portGIn, portGOut, portGOe, portGPull, portGDin;
    logic usartRxIn, usartClkIn, progSerialIn, scanDataIn, scanModeSel, scanClk;
    logic [32:0] expQ[$]; // expected {pslverr, prdata}, oldest first
    logic [15:0] cur = 16'h0; // control word last written
    logic [15:0] gReg = 16'h0; // port g word the block should hold
    int nMismatch = 0;
    int checked = 0;
    int seed = 32'h7e0b;
    pefg_override pefg_override_inst (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .periph, .portEIn, .portFIn, .portGIn, .portEOut, .portEOe, .portEPull, .portFOut,
        .portFOe, .portFPull, .portGOut, .portGOe, .portGPull, .portEDin, .portFDin, .portGDin, .usartRxIn,
        .usartClkIn, .progSerialIn, .scanDataIn, .scanModeSel, .scanClk);
    pefg_board_model pefg_board_model_inst (.portEOut, .portEOe, .portEPull, .portFOut, .portFOe, .portFPull,
        .portGOut, .portGOe, .portGPull, .ext, .portEIn, .portFIn, .portGIn);
    initial
        forever #25 ref_clk = ~ref_clk;
    // compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; a read leaves its expected answer for the monitor
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
        @(posedge ref_clk);
        if (!w)
            expQ.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // read answers are taken at the edge that completes the access
    always @(posedge ref_clk)
        if (psel && penable && !pwrite && pready === 1'b1)
            check({pslverr, prdata}, expQ.pop_front());
    // effective direction {g, f, e} from control word and direction bits
    function automatic logic [31:0] expStat(logic [15:0] c, logic [7:0] e, logic [7:0] f, logic [4:0] g,
        logic sh);
        if (c[RXEN_BIT])
            e[0] = 1'b0;
        if (c[TXEN_BIT] || c[PROG_BIT])
            e[1] = 1'b1;
        if (c[SCAN_BIT])
            f[7:4] = {1'b0, sh, 2'b00};
        if (c[LEGACY_BIT])
            f = 8'h00;
        if (c[ASYNC_BIT])
            g[4:3] = 2'b00;
        if (c[XMEM_BIT] || c[LEGACY_BIT])
            g[2:0] = 3'h7;
        return {11'h0, g, f, e};
    endfunction
    // one mode: random port words and peripheral levels, then the checks
    task automatic step(input logic [15:0] c);
        logic [31:0] r;
        logic [15:0] pe;
        logic [15:0] pf;
        logic [15:0] pg;
        logic [31:0] st;
        logic [7:0] ex; // expected port e drive values
        logic [4:0] gx; // expected port g drive values
        r = $random(seed);
        pe = r[15:0];
        pf = r[31:16];
        pg = r[23:8];
        r = $random(seed);
        @(posedge ref_clk); // new levels land on an edge, like every other input
        periph <= r[11:0];
        ext <= r[31:11];
        apb(PORTE_OFS, 1'b1, {16'h0, pe}, 33'h0);
        apb(PORTF_OFS, 1'b1, {16'h0, pf}, 33'h0); // port f levels then stay put for the step
        apb(PORTG_OFS, 1'b1, {16'h0, pg}, 33'h0);
        if (!cur[LEGACY_BIT])
            gReg = pg & 16'h1f1f; // legacy mode refuses the write
        apb(CTRL_OFS, 1'b1, {16'h0, c}, 33'h0);
        cur = c;
        st = expStat(c, pe[15:8], pf[15:8], gReg[12:8], periph.scanShiftState);
        apb(CTRL_OFS, 1'b0, 32'h0, {17'h0, c});
        apb(PORTG_OFS, 1'b0, 32'h0, {17'h0, gReg});
        apb(STAT_OFS, 1'b0, 32'h0, {1'b0, st});
        #1;
        check(portEPull[0], pe[0] & ~c[PULLUP_OFF_BIT] & (c[RXEN_BIT] | ~pe[8]));
        check(usartRxIn, portEIn[0]);
        check({scanDataIn, scanModeSel, scanClk}, {portFIn[7], portFIn[5], portFIn[4]} & {3{c[SCAN_BIT]}});
        if (c[SCAN_BIT])
            check(portFDin[7:4], 4'h0);
        if (c[PROG_BIT] && !c[TXEN_BIT])
            check(portEOut[1], periph.progSerialOut);
        // drive values of port e: data bits unless a peripheral owns the pin
        ex = pe[7:0];
        if (c[TXEN_BIT] || c[PROG_BIT])
            ex[1] = c[PROG_BIT] ? periph.progSerialOut : periph.usartTxLine;
        if (c[SYNC_BIT])
            ex[2] = periph.usartClkOut;
        for (int k = 0; k < 3; k++)
            if (c[OC3_LSB+k])
                ex[3+k] = periph.timer3Cmp[k];
        check(portEOut, ex);
        gx = gReg[4:0];
        if (c[XMEM_BIT] || c[LEGACY_BIT])
            gx[2:0] = {periph.memAle, periph.memRd, periph.memWr};
        check(portGOut, gx);
        check(portFOut, c[SCAN_BIT] ? {pf[7], periph.scanDataOut, pf[5:0]} : pf[7:0]);
        check(portFDin, portFIn & (c[SCAN_BIT] ? 8'h0f : 8'hff));
        check(portGDin, portGIn & {~{2{c[ASYNC_BIT]}}, 3'h7});
        check(portEDin, portEIn);
        check({usartClkIn, progSerialIn}, {portEIn[2], portEIn[0]});
    endtask
    // verdict and end of run
    task automatic wrapUp;
        if (expQ.size() != 0)
            nMismatch++;
        $display("compares %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog, well beyond the roughly 816 cycles the run takes
    initial
    begin
        #1000000;
        nMismatch++;
        wrapUp();
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        logic [31:0] r;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        apb(CTRL_OFS, 1'b0, 32'h0, {17'h0, CTRL_RST});
        apb(PORTE_OFS, 1'b0, 32'h0, {25'h0, PORT_RST});
        apb(8'h18, 1'b1, 32'hffffffff, 33'h0);
        apb(8'h18, 1'b0, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 9; i++)
            step(16'h1 << i);
        step(16'h0e00);
        step(16'hf000);
        step(16'h0015);
        repeat (24)
        begin
            r = $random(seed);
            step(r[15:0]);
        end
        wrapUp();
    end
endmodule // pefg_override_tb
`default_nettype wire
